/* rtl/spl_defs.svh */
// constants for the servo position loop and fault monitor
// assumes a single 50 MHz core clock and a plain strobe register port
`ifndef SPL_DEFS_SVH
`define SPL_DEFS_SVH

// ==========================================================
// timing
`define SPL_CLK_HZ 50000000
`define SPL_LOOP_US 50
`define SPL_LOOP_CYC ((`SPL_LOOP_US * (`SPL_CLK_HZ / 1000000)))
`define SPL_OC_US 200
`define SPL_OC_CYC ((`SPL_OC_US * (`SPL_CLK_HZ / 1000000)))
`define SPL_ENC_MS 20
`define SPL_MS_CYC (`SPL_CLK_HZ / 1000)
`define SPL_ENC_CYC (`SPL_ENC_MS * `SPL_MS_CYC)

// ==========================================================
// limits
`define SPL_OC_LIMIT_MA 32'h0000_4e20
`define SPL_PH_COUNTS 64
`define SPL_GAIN_SHIFT 8
`define SPL_RPM_DIV 34'h0_0000_003c

// ==========================================================
// register offsets
`define SPL_REG_CTRL 8'h00
`define SPL_REG_GEAR 8'h04
`define SPL_REG_FLIMIT 8'h08
`define SPL_REG_GAIN0 8'h0c
`define SPL_REG_GAIN1 8'h10
`define SPL_REG_STPROF 8'h14
`define SPL_REG_STLEN 8'h18
`define SPL_REG_STSEQ 8'h1c
`define SPL_REG_FAULT 8'h20
`define SPL_REG_IRQST 8'h24
`define SPL_REG_IRQMSK 8'h28
`define SPL_REG_POSCMD 8'h2c
`define SPL_REG_POSFB 8'h30
`define SPL_REG_IERR 8'h34

// ==========================================================
// field positions
`define SPL_CTRL_DUAL 0
`define SPL_CTRL_FALL 1
`define SPL_CTRL_REV 2
`define SPL_CTRL_STRUN 3
`define SPL_CTRL_LOOPEN 4
`define SPL_FCMD_CLRCUR 0
`define SPL_FCMD_CLRALL 1

// ==========================================================
// reset values
`define SPL_RST_CTRL 32'h0fa0_0010
`define SPL_RST_GEAR 16'h0101
`define SPL_RST_FLIMIT 16'h0fa0
`define SPL_RST_KP 16'h1450
`define SPL_RST_KD 16'h0bb8
`define SPL_RST_KAFF 16'h00c8

`endif

/* rtl/spl_pkg.sv */
// types shared by the servo position loop
// assumes the constants header is included where offsets are needed
package spl_pkg;
    typedef enum logic [1:0] {SPL_ST_IDLE, SPL_ST_MOVE, SPL_ST_PAUSE} spl_st_e;
    typedef logic signed [31:0] spl_pos_t;
endpackage : spl_pkg

/* rtl/spl_core.sv */
// servo position loop, command gear, self-test profiler and fault monitor
// assumes pins arrive asynchronous; current sample comes from core-clock logic
`timescale 1ns/1ps
`include "spl_defs.svh"
module spl_core #(
    parameter int unsigned LOOP_CYC = `SPL_LOOP_CYC,
    parameter int unsigned OC_CYC = `SPL_OC_CYC,
    parameter int unsigned ENC_CYC = `SPL_ENC_CYC,
    parameter int unsigned MS_CYC = `SPL_MS_CYC,
    parameter int unsigned PH_COUNTS = `SPL_PH_COUNTS,
    parameter int unsigned GAIN_SHIFT = `SPL_GAIN_SHIFT
) (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // command, encoder and motor-open pins
    input wire logic i_pul,
    input wire logic i_dir,
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    input wire logic i_motor_open,
    // current path
    input wire logic signed [15:0] i_current_meas,
    output logic signed [15:0] o_current_cmd,
    output logic signed [16:0] o_current_err,
    // status
    output logic o_fault,
    output logic o_irq
);
    localparam int unsigned TICK_HZ = `SPL_CLK_HZ / LOOP_CYC;

    // ==========================================================
    // helpers
    function automatic logic act_edge(input logic cur, input logic prv, input logic fall);
        act_edge = fall ? (prv & ~cur) : (cur & ~prv);
    endfunction : act_edge

    function automatic spl_pkg::spl_pos_t step(input logic up, input logic dn);
        step = (up & ~dn) ? 32'sh1 : ((dn & ~up) ? -32'sh1 : 32'sh0);
    endfunction : step

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction : mag

    // ==========================================================
    // registers
    logic [31:0] ctrl_q;
    logic [7:0] gear_num_q, gear_den_q;
    logic [15:0] flimit_q, kp_q, kd_q, kaff_q, vtop_q, accel_q, interval_q, repeat_q;
    logic [31:0] stlen_q;
    logic [3:0] fault_now_q, fault_hist_q;
    logic [4:0] irq_stat_q, irq_mask_q;
    logic wr_ctrl, clr_cur, clr_all, rd_irq, st_done;
    logic [3:0] fault_set;

    assign wr_ctrl = i_wr && i_addr == `SPL_REG_CTRL;
    assign clr_cur = i_wr && i_addr == `SPL_REG_FAULT && i_wdata[`SPL_FCMD_CLRCUR];
    assign clr_all = i_wr && i_addr == `SPL_REG_FAULT && i_wdata[`SPL_FCMD_CLRALL];
    assign rd_irq = i_rd && i_addr == `SPL_REG_IRQST;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ctrl_q <= `SPL_RST_CTRL;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ctrl_q <= i_wdata;
            end else if (st_done) begin
                ctrl_q[`SPL_CTRL_STRUN] <= 1'b0;
            end
        end
    end

    // zero would stall the gear divider, so it is held at one
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            {gear_den_q, gear_num_q} <= `SPL_RST_GEAR;
            flimit_q <= `SPL_RST_FLIMIT;
            kp_q <= `SPL_RST_KP;
            kd_q <= `SPL_RST_KD;
            kaff_q <= `SPL_RST_KAFF;
            {accel_q, vtop_q} <= 32'h0;
            stlen_q <= 32'h0;
            {repeat_q, interval_q} <= 32'h0;
            irq_mask_q <= 5'h0;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                `SPL_REG_GEAR: begin
                    gear_num_q <= (i_wdata[7:0] == 8'h0) ? 8'h1 : i_wdata[7:0];
                    gear_den_q <= (i_wdata[15:8] == 8'h0) ? 8'h1 : i_wdata[15:8];
                end
                `SPL_REG_FLIMIT: flimit_q <= i_wdata[15:0];
                `SPL_REG_GAIN0: {kd_q, kp_q} <= i_wdata;
                `SPL_REG_GAIN1: kaff_q <= i_wdata[15:0];
                `SPL_REG_STPROF: {accel_q, vtop_q} <= i_wdata;
                `SPL_REG_STLEN: stlen_q <= i_wdata;
                `SPL_REG_STSEQ: {repeat_q, interval_q} <= i_wdata;
                `SPL_REG_IRQMSK: irq_mask_q <= i_wdata[4:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // pin synchronisers
    logic [4:0] sy1_q, sy2_q, syp_q;
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            sy1_q <= 5'h0;
            sy2_q <= 5'h0;
            syp_q <= 5'h0;
        end else if (i_ce) begin
            sy1_q <= {i_motor_open, i_enc_b, i_enc_a, i_dir, i_pul};
            sy2_q <= sy1_q;
            syp_q <= sy2_q;
        end
    end

    // ==========================================================
    // command decode and gear
    logic pul_act, dir_act, dir_lvl, up_raw, dn_raw, cmd_up, cmd_dn, g_up, g_dn, rev, dual;
    logic signed [9:0] gacc_q, gnum_s, gden_s;
    assign rev = ctrl_q[`SPL_CTRL_REV];
    assign dual = ctrl_q[`SPL_CTRL_DUAL];
    assign pul_act = act_edge(sy2_q[0], syp_q[0], ctrl_q[`SPL_CTRL_FALL]);
    assign dir_act = act_edge(sy2_q[1], syp_q[1], ctrl_q[`SPL_CTRL_FALL]);
    assign dir_lvl = sy2_q[1] ^ rev;
    // only edges count in dual mode, so a held idle line is harmless
    assign up_raw = rev ? dir_act : pul_act;
    assign dn_raw = rev ? pul_act : dir_act;
    assign cmd_up = dual ? (up_raw & ~dn_raw) : (pul_act & dir_lvl);
    assign cmd_dn = dual ? (dn_raw & ~up_raw) : (pul_act & ~dir_lvl);
    assign gnum_s = signed'({2'b00, gear_num_q});
    assign gden_s = signed'({2'b00, gear_den_q});
    assign g_up = gacc_q >= gden_s;
    assign g_dn = gacc_q <= -gden_s;

    // one output count per cycle; pulses must be at least 255 cycles apart
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            gacc_q <= 10'sh000;
        end else if (i_ce) begin
            gacc_q <= gacc_q - (g_up ? gden_s : (g_dn ? -gden_s : 10'sh000))
                + (cmd_up ? gnum_s : (cmd_dn ? -gnum_s : 10'sh000));
        end
    end

    // ==========================================================
    // quadrature decode, independent of the line-count setting
    logic enc_up, enc_dn, enc_bad;
    always_comb begin
        enc_up = 1'b0;
        enc_dn = 1'b0;
        enc_bad = 1'b0;
        case ({syp_q[3:2], sy2_q[3:2]})
            4'h1, 4'h7, 4'he, 4'h8: enc_up = 1'b1;
            4'h2, 4'hb, 4'hd, 4'h4: enc_dn = 1'b1;
            4'h3, 4'h6, 4'h9, 4'hc: enc_bad = 1'b1;
            default: ;
        endcase
    end

    // ==========================================================
    // positions
    spl_pkg::spl_pos_t pcmd_q, pfb_q, perr;
    logic st_up, st_dn;
    assign perr = pcmd_q - pfb_q;
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pcmd_q <= 32'sh0;
            pfb_q <= 32'sh0;
        end else if (i_ce) begin
            pcmd_q <= pcmd_q + step(g_up, g_dn) + step(st_up, st_dn);
            pfb_q <= pfb_q + step(enc_up, enc_dn);
        end
    end

    // ==========================================================
    // position loop
    logic [15:0] tick_cnt_q;
    logic tick, fault_any;
    spl_pkg::spl_pos_t perr_prev_q, pcmd_prev_q, vel_prev_q, vel_now;
    logic signed [49:0] u_sum, u_sh;
    logic signed [15:0] u_sat;
    assign tick = tick_cnt_q == 16'(LOOP_CYC - 1);
    assign vel_now = pcmd_q - pcmd_prev_q;
    assign fault_any = |fault_now_q;
    assign u_sum = signed'({34'h0, kp_q}) * 50'(perr)
        + signed'({34'h0, kd_q}) * 50'(perr - perr_prev_q)
        + signed'({34'h0, kaff_q}) * 50'(vel_now - vel_prev_q);
    assign u_sh = u_sum >>> GAIN_SHIFT;
    assign u_sat = (u_sh > 50'sh7fff) ? 16'sh7fff : ((u_sh < -50'sh8000) ? -16'sh8000 : 16'(u_sh));

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            tick_cnt_q <= 16'h0;
            perr_prev_q <= 32'sh0;
            pcmd_prev_q <= 32'sh0;
            vel_prev_q <= 32'sh0;
        end else if (i_ce) begin
            tick_cnt_q <= tick ? 16'h0 : tick_cnt_q + 16'h1;
            if (tick) begin
                perr_prev_q <= perr;
                pcmd_prev_q <= pcmd_q;
                vel_prev_q <= vel_now;
            end
        end
    end

    // protection drops the drive at once, not at the next tick
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_current_cmd <= 16'sh0;
            o_current_err <= 17'sh0;
        end else if (i_ce) begin
            if (fault_any || !ctrl_q[`SPL_CTRL_LOOPEN]) begin
                o_current_cmd <= 16'sh0;
            end else if (tick) begin
                o_current_cmd <= u_sat;
            end
            o_current_err <= 17'(o_current_cmd) - 17'(i_current_meas);
        end
    end

    // ==========================================================
    // fault detection
    logic [23:0] oc_cnt_q, en_cnt_q;
    logic [15:0] ph_cnt_q;
    logic oc_over, sat_drive, ph_opp, oc_trip, ph_trip, en_trip, fol_trip;
    assign oc_over = mag(32'(i_current_meas)) > `SPL_OC_LIMIT_MA;
    assign sat_drive = mag(32'(o_current_cmd)) >= 32'h0000_7fff;
    assign ph_opp = sat_drive && (o_current_cmd[15] ? enc_up : enc_dn);
    assign oc_trip = oc_over && oc_cnt_q == 24'(OC_CYC - 1);
    // drive pinned while the shaft runs away means swapped phases
    assign ph_trip = sy2_q[4] || (ph_opp && ph_cnt_q == 16'(PH_COUNTS - 1));
    assign en_trip = enc_bad || (sat_drive && en_cnt_q == 24'(ENC_CYC - 1));
    assign fol_trip = mag(perr) >= {16'h0, flimit_q};
    assign fault_set = {fol_trip, en_trip, ph_trip, oc_trip};

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            oc_cnt_q <= 24'h0;
            en_cnt_q <= 24'h0;
            ph_cnt_q <= 16'h0;
        end else if (i_ce) begin
            oc_cnt_q <= (oc_over && !oc_trip) ? oc_cnt_q + 24'h1 : 24'h0;
            en_cnt_q <= (sat_drive && !enc_up && !enc_dn && !en_trip) ? en_cnt_q + 24'h1 : 24'h0;
            if (!sat_drive || (o_current_cmd[15] ? enc_dn : enc_up)) begin
                ph_cnt_q <= 16'h0;
            end else if (ph_opp && !ph_trip) begin
                ph_cnt_q <= ph_cnt_q + 16'h1;
            end
        end
    end

    // a fault seen in the clearing cycle stays set
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            fault_now_q <= 4'h0;
            fault_hist_q <= 4'h0;
            o_fault <= 1'b0;
        end else if (i_ce) begin
            fault_now_q <= ((clr_cur || clr_all) ? 4'h0 : fault_now_q) | fault_set;
            fault_hist_q <= (clr_all ? 4'h0 : fault_hist_q) | fault_set;
            o_fault <= |(((clr_cur || clr_all) ? 4'h0 : fault_now_q) | fault_set);
        end
    end

    // ==========================================================
    // self-test profiler
    spl_pkg::spl_st_e st_q;
    logic st_neg_q, st_step, st_dec;
    logic [31:0] rem_q, vel_q, pacc_q, adist_q, tmr_q, vmax, dv;
    logic [15:0] rep_q;
    logic [33:0] vmax_w, dv_w;
    logic [17:0] cpr;
    assign cpr = {ctrl_q[31:16], 2'b00};
    assign vmax_w = (34'(vtop_q) * 34'(cpr)) / `SPL_RPM_DIV;
    assign dv_w = (34'(accel_q) * 34'(cpr)) / 34'(TICK_HZ);
    assign vmax = vmax_w[31:0];
    assign dv = (dv_w == 34'h0) ? 32'h1 : dv_w[31:0];
    assign st_step = st_q == spl_pkg::SPL_ST_MOVE && pacc_q >= TICK_HZ && rem_q != 32'h0;
    assign st_dec = rem_q <= adist_q;
    assign st_up = st_step & ~st_neg_q;
    assign st_dn = st_step & st_neg_q;
    assign st_done = i_ce && st_q == spl_pkg::SPL_ST_PAUSE && tmr_q == 32'h0 && st_neg_q
        && (rep_q + 16'h1 >= repeat_q);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_q <= spl_pkg::SPL_ST_IDLE;
            st_neg_q <= 1'b0;
            {rem_q, vel_q, pacc_q, adist_q, tmr_q} <= 160'h0;
            rep_q <= 16'h0;
        end else if (i_ce) begin
            case (st_q)
                spl_pkg::SPL_ST_IDLE: begin
                    if (ctrl_q[`SPL_CTRL_STRUN] && !fault_any) begin
                        st_q <= spl_pkg::SPL_ST_MOVE;
                        st_neg_q <= 1'b0;
                        rep_q <= 16'h0;
                        rem_q <= stlen_q;
                        {vel_q, pacc_q, adist_q} <= 96'h0;
                    end
                end
                spl_pkg::SPL_ST_MOVE: begin
                    pacc_q <= pacc_q - (st_step ? TICK_HZ : 32'h0) + (tick ? vel_q : 32'h0);
                    rem_q <= rem_q - (st_step ? 32'h1 : 32'h0);
                    if (st_step && !st_dec && vel_q < vmax) begin
                        adist_q <= adist_q + 32'h1;
                    end
                    if (tick) begin
                        if (st_dec) begin
                            vel_q <= (vel_q > dv + dv) ? vel_q - dv : dv;
                        end else begin
                            vel_q <= (vel_q + dv > vmax) ? vmax : vel_q + dv;
                        end
                    end
                    if (rem_q == 32'h0) begin
                        st_q <= spl_pkg::SPL_ST_PAUSE;
                        tmr_q <= 32'(interval_q) * MS_CYC;
                    end
                end
                spl_pkg::SPL_ST_PAUSE: begin
                    if (tmr_q != 32'h0) begin
                        tmr_q <= tmr_q - 32'h1;
                    end else if (st_done) begin
                        st_q <= spl_pkg::SPL_ST_IDLE;
                    end else begin
                        st_q <= spl_pkg::SPL_ST_MOVE;
                        st_neg_q <= ~st_neg_q;
                        rep_q <= rep_q + (st_neg_q ? 16'h1 : 16'h0);
                        rem_q <= stlen_q;
                        {vel_q, pacc_q, adist_q} <= 96'h0;
                    end
                end
                default: st_q <= spl_pkg::SPL_ST_IDLE;
            endcase
            if (fault_any || !ctrl_q[`SPL_CTRL_STRUN]) begin
                st_q <= spl_pkg::SPL_ST_IDLE;
            end
        end
    end

    // ==========================================================
    // interrupts and read port
    logic [31:0] rd_mux;
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            irq_stat_q <= 5'h0;
        end else if (i_ce) begin
            irq_stat_q <= (rd_irq ? 5'h0 : irq_stat_q) | {st_done, fault_set};
        end
    end
    assign o_irq = |(irq_stat_q & irq_mask_q);

    always_comb begin
        case (i_addr)
            `SPL_REG_CTRL: rd_mux = ctrl_q;
            `SPL_REG_GEAR: rd_mux = {16'h0, gear_den_q, gear_num_q};
            `SPL_REG_FLIMIT: rd_mux = {16'h0, flimit_q};
            `SPL_REG_GAIN0: rd_mux = {kd_q, kp_q};
            `SPL_REG_GAIN1: rd_mux = {16'h0, kaff_q};
            `SPL_REG_STPROF: rd_mux = {accel_q, vtop_q};
            `SPL_REG_STLEN: rd_mux = stlen_q;
            `SPL_REG_STSEQ: rd_mux = {repeat_q, interval_q};
            `SPL_REG_FAULT: rd_mux = {20'h0, fault_hist_q, 4'h0, fault_now_q};
            `SPL_REG_IRQST: rd_mux = {27'h0, irq_stat_q};
            `SPL_REG_IRQMSK: rd_mux = {27'h0, irq_mask_q};
            `SPL_REG_POSCMD: rd_mux = pcmd_q;
            `SPL_REG_POSFB: rd_mux = pfb_q;
            `SPL_REG_IERR: rd_mux = 32'(o_current_err);
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h0;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rd_mux : 32'h0;
        end
    end

    // ==========================================================
    // checks
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    a_gear_range: assert property (gear_num_q != 8'h0 && gear_den_q != 8'h0)
        else $error("gear setting left the 1..255 range");
    a_follow_trip: assert property (i_ce && fol_trip |=> fault_now_q[3] && fault_hist_q[3])
        else $error("following error at limit did not raise fault");
    a_quad_count: assert property (i_ce && enc_up |=> pfb_q == $past(pfb_q) + 32'sh1)
        else $error("quadrature edge not counted");
    a_hist_cover: assert property ((fault_now_q & ~fault_hist_q) == 4'h0)
        else $error("present fault missing from history");
    a_clear_current: assert property (i_ce && clr_cur && !clr_all
        |=> (fault_hist_q & $past(fault_hist_q)) == $past(fault_hist_q))
        else $error("clear-current erased history");
    a_oc_trip: assert property (i_ce && oc_trip |=> fault_now_q[0] ##1 o_fault || fault_now_q[0])
        else $error("sustained over-current not flagged");
    a_ierr_trace: assert property (i_ce |=> o_current_err == $past(17'(o_current_cmd) - 17'(i_current_meas)))
        else $error("current following error trace wrong");
    a_enc_bad: assert property (i_ce && enc_bad |=> fault_now_q[2])
        else $error("invalid encoder transition not flagged");
    a_pause_still: assert property (st_q == spl_pkg::SPL_ST_PAUSE |-> !st_up && !st_dn)
        else $error("self-test moved during pause");
endmodule : spl_core

/* tb/spl_far_end.sv */
// far-end model: step command source and quadrature encoder
// assumes pins move right after a rising core clock edge
`timescale 1ns/1ps
module spl_far_end (
    // clock
    input wire logic i_core_clk,
    // command and encoder pins
    output logic o_pul,
    output logic o_dir,
    output logic o_enc_a,
    output logic o_enc_b
);
    logic [1:0] ph_q = 2'h0;
    initial o_pul = 1'b0;
    initial o_dir = 1'b0;
    assign o_enc_b = ph_q[1];
    assign o_enc_a = ph_q[1] ^ ph_q[0];
    // four cycles high and low, tail lets the gear drain
    task automatic steps(input int n, input logic d);
        @(posedge i_core_clk);
        o_dir <= d;
        repeat (n) begin
            repeat (4) @(posedge i_core_clk);
            o_pul <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            o_pul <= 1'b0;
        end
        repeat (12) @(posedge i_core_clk);
    endtask : steps
    // s of 1 counts up, 3 down, 2 flips both channels at once
    task automatic enc(input int n, input logic [1:0] s);
        repeat (n) begin
            repeat (4) @(posedge i_core_clk);
            ph_q <= ph_q + s;
        end
        repeat (8) @(posedge i_core_clk);
    endtask : enc
endmodule : spl_far_end

/* tb/tb_servo_position_loop_and_fault_monitor.sv */
// self-checking bench for the servo position loop core
// assumes the far-end model owns the command and encoder pins
`timescale 1ns/1ps
`include "spl_defs.svh"
module tb_servo_position_loop_and_fault_monitor;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic wr = 1'b0, rd = 1'b0, motor_open = 1'b0, ce = 1'b1, d;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic pul, dir, enc_a, enc_b, fault, irq;
    logic signed [15:0] meas = 16'sh0, ccmd;
    logic signed [16:0] cerr;
    int fails = 0, tests_run = 0, pos = 0, fb = 0, n, num, den;
    initial forever #10 core_clk = ~core_clk;
    spl_core #(.LOOP_CYC(50), .OC_CYC(20), .ENC_CYC(200), .MS_CYC(10), .PH_COUNTS(4)) dut (
        .i_core_clk(core_clk), .i_reset(reset), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pul(pul), .i_dir(dir), .i_enc_a(enc_a),
        .i_enc_b(enc_b), .i_motor_open(motor_open), .i_current_meas(meas), .o_current_cmd(ccmd),
        .o_current_err(cerr), .o_fault(fault), .o_irq(irq));
    spl_far_end far (.i_core_clk(core_clk), .o_pul(pul), .o_dir(dir), .o_enc_a(enc_a), .o_enc_b(enc_b));
    function automatic int exp_sign(input logic [2:0] c, input logic dl);
        return ((c[`SPL_CTRL_DUAL] ? 1'b1 : dl) ^ c[`SPL_CTRL_REV]) ? 1 : -1;
    endfunction : exp_sign
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask : rchk
    task automatic complete_run();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // whole run needs about four thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(86200));
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        rchk(`SPL_REG_CTRL, `SPL_RST_CTRL, "ctrl");
        rchk(8'h3c, 32'h0, "hole");
        wr_reg(`SPL_REG_GEAR, 32'h0000_ffff);
        rchk(`SPL_REG_GEAR, 32'h0000_ffff, "gear max");
        wr_reg(`SPL_REG_GEAR, 32'h0);
        rchk(`SPL_REG_GEAR, 32'h0000_0101, "gear min");
        $display("registers done");
        // dir settles in step mode so dual mode sees no stray edge
        for (int m = 0; m < 8; m++) begin
            d = 1'($urandom);
            n = 1 + $urandom % 16;
            far.steps(0, d);
            wr_reg(`SPL_REG_CTRL, 32'(m));
            far.steps(n, d);
            pos += n * exp_sign(3'(m), d);
            wr_reg(`SPL_REG_CTRL, 32'h0);
            rchk(`SPL_REG_POSCMD, 32'(pos), "poscmd");
        end
        num = 1 + $urandom % 8;
        den = 1 + $urandom % 8;
        n = 1 + $urandom % 16;
        wr_reg(`SPL_REG_GEAR, 32'((den << 8) | num));
        far.steps(n, 1'b1);
        pos += n * num / den;
        rchk(`SPL_REG_POSCMD, 32'(pos), "geared");
        $display("command done");
        wr_reg(`SPL_REG_CTRL, {16'($urandom), 16'h0});
        n = 1 + $urandom % 30;
        far.enc(n, 2'h1);
        fb = n;
        n = 1 + $urandom % 20;
        far.enc(n, 2'h3);
        fb -= n;
        rchk(`SPL_REG_POSFB, 32'(fb), "posfb");
        n = (pos > fb) ? pos - fb : fb - pos;
        wr_reg(`SPL_REG_FLIMIT, 32'(n + 1));
        rchk(`SPL_REG_FAULT, 32'h0, "below");
        wr_reg(`SPL_REG_IRQMSK, 32'h8);
        wr_reg(`SPL_REG_FLIMIT, 32'(n));
        rchk(`SPL_REG_FAULT, 32'h808, "at limit");
        chk("fault irq", 32'({fault, irq}), 32'h3);
        wr_reg(`SPL_REG_FLIMIT, 32'h0000_ffff);
        rchk(`SPL_REG_IRQST, 32'h8, "irqst");
        rchk(`SPL_REG_IRQST, 32'h0, "irqst clr");
        chk("irq low", 32'(irq), 32'h0);
        wr_reg(`SPL_REG_FAULT, 32'h1);
        rchk(`SPL_REG_FAULT, 32'h800, "clr cur");
        $display("following done");
        @(posedge core_clk);
        motor_open <= 1'b1;
        repeat (4) @(posedge core_clk);
        motor_open <= 1'b0;
        far.enc(1, 2'h2);
        rchk(`SPL_REG_FAULT, 32'he06, "phase enc");
        @(posedge core_clk);
        meas <= 16'sd20000;
        repeat (30) @(posedge core_clk);
        rchk(`SPL_REG_FAULT, 32'he06, "at 20 A");
        chk("cerr", 32'(cerr), 32'(-17'sd20000));
        @(posedge core_clk);
        meas <= 16'sd20001;
        repeat (30) @(posedge core_clk);
        rchk(`SPL_REG_FAULT, 32'hf07, "over 20 A");
        @(posedge core_clk);
        meas <= 16'sh0;
        wr_reg(`SPL_REG_FAULT, 32'h2);
        rchk(`SPL_REG_FAULT, 32'h0, "clr all");
        $display("faults done");
        // clock enable low must swallow the write strobe
        @(posedge core_clk);
        ce <= 1'b0;
        wr_reg(`SPL_REG_FLIMIT, 32'h1);
        ce <= 1'b1;
        rchk(`SPL_REG_FLIMIT, 32'h0000_ffff, "ce hold");
        // at rest the error history terms are zero, only the proportional term drives
        wr_reg(`SPL_REG_CTRL, 32'h10);
        repeat (60) @(posedge core_clk);
        #1;
        n = (int'(`SPL_RST_KP) * (pos - fb)) >>> 8;
        chk("loop out", 32'(ccmd), 32'(n));
        chk("cerr loop", 32'(cerr), 32'(n));
        $display("loop done");
        rchk(`SPL_REG_IRQST, 32'h7, "fault irqst");
        wr_reg(`SPL_REG_STPROF, 32'hffff_ffff);
        wr_reg(`SPL_REG_STLEN, 32'h4);
        wr_reg(`SPL_REG_STSEQ, 32'h0001_0001);
        wr_reg(`SPL_REG_IRQMSK, 32'h10);
        wr_reg(`SPL_REG_CTRL, 32'hffff_0008);
        for (int k = 0; k < 6000 && !irq; k++) begin
            @(posedge core_clk);
        end
        rchk(`SPL_REG_CTRL, 32'hffff_0000, "st done");
        rchk(`SPL_REG_POSCMD, 32'(pos), "st return");
        rchk(`SPL_REG_IRQST, 32'h10, "st irq");
        $display("self-test done");
        complete_run();
    end
endmodule : tb_servo_position_loop_and_fault_monitor
